// ---- logic/gpmc_top.sv ----
// Chosen here: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ns

module gpmc_top #(
	parameter int ADDR_W = 8
) (
	input  wire logic               i_sys_clk,
	input  wire logic               i_resetn,
	input  wire logic               i_hsel,
	input  wire logic [ADDR_W-1:0]  i_haddr,
	input  wire logic [1:0]         i_htrans,
	input  wire logic               i_hwrite,
	input  wire logic [2:0]         i_hsize,
	input  wire logic               i_hready,
	input  wire logic [31:0]        i_hwdata,
	output logic      [31:0]        o_hrdata,
	output logic                    o_hreadyout,
	output logic                    o_hresp,
	input  wire logic               i_meas_tick,
	input  wire logic signed [15:0] i_current,
	input  wire logic signed [15:0] i_avg_current,
	input  wire logic [15:0]        i_voltage,
	input  wire logic               i_host_activity,
	input  wire logic               i_i2c_addr_match,
	input  wire logic               i_host_cmd,
	input  wire logic               i_host_cmd_done,
	input  wire logic               i_cal_done,
	input  wire logic               i_ocv_done,
	input  wire logic               i_wake_cmp,
	input  wire logic               i_ext_power,
	input  wire logic               i_battery_insert_pin,
	input  wire logic               i_therm_present,
	output logic                    o_hfosc_en,
	output logic                    o_cpu_halt,
	output logic                    o_algo_run,
	output logic                    o_meas_req,
	output logic                    o_cal_start,
	output logic                    o_ocv_start,
	output logic                    o_battery_good_output,
	output logic [1:0]              o_profile_sel,
	output logic                    o_profile_load,
	output logic                    o_wake_cmp_en,
	output logic [2:0]              o_wake_range_select
);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [15:0] mag(input logic signed [15:0] v);
		mag = v[15] ? 16'(-v) : 16'(v);
	endfunction

	function automatic logic [2:0] mode_code(input gpmc_pkg::gpmc_state_e s);
		case (s)
			gpmc_pkg::ST_NORMAL:  mode_code = gpmc_pkg::MODE_NORMAL;
			gpmc_pkg::ST_CAL:     mode_code = gpmc_pkg::MODE_CAL;
			gpmc_pkg::ST_LIGHT:   mode_code = gpmc_pkg::MODE_LIGHT;
			gpmc_pkg::ST_DEEP:    mode_code = gpmc_pkg::MODE_DEEP;
			gpmc_pkg::ST_HIB:     mode_code = gpmc_pkg::MODE_HIB;
			gpmc_pkg::ST_INIT:    mode_code = gpmc_pkg::MODE_INIT;
			default:              mode_code = gpmc_pkg::MODE_INSCHK;
		endcase
	endfunction

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	logic [3:0] pin_raw;
	logic [3:0] sync1_r;
	logic [3:0] sync2_r;

	assign pin_raw = {i_therm_present, i_battery_insert_pin,
	                  i_ext_power, i_wake_cmp};

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_sync
			always_ff @(posedge i_sys_clk) begin
				if (!i_resetn) begin
					sync1_r[g] <= 1'b0;
					sync2_r[g] <= 1'b0;
				end else begin
					sync1_r[g] <= pin_raw[g];
					sync2_r[g] <= sync1_r[g];
				end
			end
		end
	endgenerate

	logic wake_s;
	logic ext_pwr_s;
	logic ins_pin_s;
	logic therm_s;
	assign wake_s    = sync2_r[0];
	assign ext_pwr_s = sync2_r[1];
	assign ins_pin_s = sync2_r[2];
	assign therm_s   = sync2_r[3];

	// ------------------------------------------------------------
	// AHB-Lite slave
	// ------------------------------------------------------------
	logic [gpmc_pkg::CTRL_W-1:0] ctrl_r;
	logic [15:0]                 idle_thr_r;
	logic [15:0]                 hib_i_r;
	logic [15:0]                 hib_v_r;
	logic                        wr_pend_r;
	logic [ADDR_W-1:0]           wr_addr_r;
	logic                        cmd_stb_r;
	logic [7:0]                  cmd_r;
	logic [31:0]                 status_w;
	logic                        addr_ok;

	// Zero wait states, so the slave never stalls the bus
	assign addr_ok = i_hsel && i_hready &&
	                 i_htrans == gpmc_pkg::HTRANS_NONSEQ;

	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			o_hreadyout <= 1'b1;
			o_hresp     <= gpmc_pkg::HRESP_OKAY;
			o_hrdata    <= 32'h0000_0000;
			wr_pend_r   <= 1'b0;
			wr_addr_r   <= '0;
		end else begin
			o_hreadyout <= 1'b1;
			o_hresp     <= gpmc_pkg::HRESP_OKAY;
			wr_pend_r   <= addr_ok && i_hwrite;
			wr_addr_r   <= i_haddr;
			if (addr_ok && !i_hwrite) begin
				if (i_haddr == ADDR_W'(gpmc_pkg::REG_CTRL)) begin
					o_hrdata <= 32'(ctrl_r);
				end else if (i_haddr == ADDR_W'(gpmc_pkg::REG_IDLE_THR)) begin
					o_hrdata <= 32'(idle_thr_r);
				end else if (i_haddr == ADDR_W'(gpmc_pkg::REG_HIB_I)) begin
					o_hrdata <= 32'(hib_i_r);
				end else if (i_haddr == ADDR_W'(gpmc_pkg::REG_HIB_V)) begin
					o_hrdata <= 32'(hib_v_r);
				end else if (i_haddr == ADDR_W'(gpmc_pkg::REG_STATUS)) begin
					o_hrdata <= status_w;
				end else begin
					o_hrdata <= 32'h0000_0000;
				end
			end
		end
	end

	// Register writes land in the data phase
	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			ctrl_r     <= gpmc_pkg::CTRL_RST;
			idle_thr_r <= gpmc_pkg::IDLE_THR_RST;
			hib_i_r    <= gpmc_pkg::HIB_I_RST;
			hib_v_r    <= gpmc_pkg::HIB_V_RST;
			cmd_stb_r  <= 1'b0;
			cmd_r      <= 8'h00;
		end else begin
			cmd_stb_r <= 1'b0;
			if (wr_pend_r) begin
				if (wr_addr_r == ADDR_W'(gpmc_pkg::REG_CTRL)) begin
					ctrl_r <= i_hwdata[gpmc_pkg::CTRL_W-1:0];
				end else if (wr_addr_r == ADDR_W'(gpmc_pkg::REG_IDLE_THR)) begin
					idle_thr_r <= i_hwdata[15:0];
				end else if (wr_addr_r == ADDR_W'(gpmc_pkg::REG_HIB_I)) begin
					hib_i_r <= i_hwdata[15:0];
				end else if (wr_addr_r == ADDR_W'(gpmc_pkg::REG_HIB_V)) begin
					hib_v_r <= i_hwdata[15:0];
				end else if (wr_addr_r == ADDR_W'(gpmc_pkg::REG_CMD)) begin
					cmd_stb_r <= 1'b1;
					cmd_r     <= i_hwdata[7:0];
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Decoded conditions
	// ------------------------------------------------------------
	logic cmd_hib;
	logic cmd_pres;
	logic cmd_abs;
	logic cmd_prof;
	logic cur_low;
	logic wake_evt;
	logic ins_det;
	logic rem_det;
	logic hib_qual;

	assign cmd_hib  = cmd_stb_r && cmd_r == gpmc_pkg::CMD_SET_HIB;
	assign cmd_pres = cmd_stb_r && cmd_r == gpmc_pkg::CMD_BAT_PRES;
	assign cmd_abs  = cmd_stb_r && cmd_r == gpmc_pkg::CMD_BAT_ABS;
	assign cmd_prof = cmd_stb_r && cmd_r[7:2] == gpmc_pkg::CMD_PROF_BASE;
	assign cur_low  = mag(i_current) < idle_thr_r;
	// Comparator only counts when a sense range is selected
	assign wake_evt = wake_s && (ctrl_r[gpmc_pkg::CTRL_SNS_HI] ||
	                             ctrl_r[gpmc_pkg::CTRL_SNS_LO]);
	assign ins_det  = ctrl_r[gpmc_pkg::CTRL_INSDET] &&
	                  (therm_s || ins_pin_s);
	assign rem_det  = ctrl_r[gpmc_pkg::CTRL_INSDET] &&
	                  !therm_s && !ins_pin_s;

	logic               hib_req_r;
	logic               ocv_valid_r;
	logic               ocv_done_r;
	logic               bat_pres_r;
	gpmc_pkg::gpmc_state_e state_r;

	assign hib_qual = ocv_valid_r &&
	    ((hib_req_r && mag(i_avg_current) < hib_i_r) ||
	     i_voltage < hib_v_r);

	assign status_w = 32'({
	    o_profile_sel,
	    ctrl_r[gpmc_pkg::CTRL_LIGHT],
	    bat_pres_r,
	    hib_req_r,
	    state_r == gpmc_pkg::ST_CAL,
	    ocv_done_r,
	    mode_code(state_r)});

	// ------------------------------------------------------------
	// Battery presence and profile selection
	// ------------------------------------------------------------
	// Presence reports from the host win over a pin-based removal
	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			// The pack powers the device at power-on, so it counts as present
			bat_pres_r     <= 1'b1;
			o_profile_sel  <= 2'h0;
			o_profile_load <= 1'b0;
		end else begin
			o_profile_load <= 1'b0;
			if (cmd_pres || ins_det) begin
				bat_pres_r <= 1'b1;
			end else if (cmd_abs || rem_det) begin
				bat_pres_r <= 1'b0;
			end
			if (cmd_prof) begin
				o_profile_sel  <= cmd_r[1:0];
				o_profile_load <= 1'b1;
			end else if (state_r == gpmc_pkg::ST_INIT && i_ocv_done) begin
				o_profile_load <= 1'b1;
			end
		end
	end

	// Request is consumed on hibernate entry; a new request wins
	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			hib_req_r <= 1'b0;
		end else if (cmd_hib) begin
			hib_req_r <= 1'b1;
		end else if (state_r == gpmc_pkg::ST_HIB) begin
			hib_req_r <= 1'b0;
		end
	end

	// OCV validity and done flag, set wins over the re-init clear
	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			ocv_valid_r <= 1'b0;
			ocv_done_r  <= 1'b0;
		end else if (state_r == gpmc_pkg::ST_INIT && i_ocv_done) begin
			ocv_valid_r <= 1'b1;
			ocv_done_r  <= 1'b1;
		end else if (o_ocv_start || !bat_pres_r) begin
			ocv_valid_r <= 1'b0;
			ocv_done_r  <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Power mode sequencer
	// ------------------------------------------------------------
	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			state_r     <= gpmc_pkg::ST_INIT;
			o_cal_start <= 1'b0;
			o_ocv_start <= 1'b1;
		end else begin
			o_cal_start <= 1'b0;
			o_ocv_start <= 1'b0;
			case (state_r)
				gpmc_pkg::ST_NORMAL: begin
					if (!bat_pres_r && ext_pwr_s) begin
						state_r <= gpmc_pkg::ST_INSCHK;
					end else if (i_meas_tick) begin
						if (hib_qual) begin
							state_r <= gpmc_pkg::ST_HIB;
						end else if (ctrl_r[gpmc_pkg::CTRL_DEEP] && cur_low) begin
							state_r     <= gpmc_pkg::ST_CAL;
							o_cal_start <= 1'b1;
						end else if (ctrl_r[gpmc_pkg::CTRL_LIGHT] && cur_low) begin
							state_r <= gpmc_pkg::ST_LIGHT;
						end
					end
				end
				gpmc_pkg::ST_CAL: begin
					// Calibration is abandoned if the load returns
					if (!cur_low || wake_evt) begin
						state_r <= gpmc_pkg::ST_NORMAL;
					end else if (i_cal_done) begin
						state_r <= gpmc_pkg::ST_DEEP;
					end
				end
				gpmc_pkg::ST_LIGHT: begin
					if (i_host_activity || !cur_low || wake_evt ||
					    (!bat_pres_r && ext_pwr_s)) begin
						state_r <= gpmc_pkg::ST_NORMAL;
					end
				end
				gpmc_pkg::ST_DEEP: begin
					if (!cur_low || wake_evt ||
					    (!bat_pres_r && ext_pwr_s)) begin
						state_r <= gpmc_pkg::ST_NORMAL;
					end
				end
				gpmc_pkg::ST_HIB: begin
					// Bus traffic for other targets is ignored here
					if (i_i2c_addr_match) begin
						state_r     <= gpmc_pkg::ST_INIT;
						o_ocv_start <= 1'b1;
					end
				end
				gpmc_pkg::ST_INSCHK: begin
					if (bat_pres_r) begin
						state_r     <= gpmc_pkg::ST_INIT;
						o_ocv_start <= 1'b1;
					end else if (i_host_cmd) begin
						state_r <= gpmc_pkg::ST_INSWAKE;
					end
				end
				gpmc_pkg::ST_INSWAKE: begin
					if (i_host_cmd_done) begin
						state_r <= gpmc_pkg::ST_INSCHK;
					end
				end
				gpmc_pkg::ST_INIT: begin
					if (i_ocv_done) begin
						state_r <= gpmc_pkg::ST_NORMAL;
					end
				end
				default: begin
					state_r <= gpmc_pkg::ST_NORMAL;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Mode-dependent outputs
	// ------------------------------------------------------------
	logic measuring;
	assign measuring = state_r == gpmc_pkg::ST_NORMAL ||
	                   state_r == gpmc_pkg::ST_LIGHT ||
	                   state_r == gpmc_pkg::ST_DEEP ||
	                   state_r == gpmc_pkg::ST_CAL;

	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			o_hfosc_en            <= 1'b1;
			o_cpu_halt            <= 1'b0;
			o_algo_run            <= 1'b0;
			o_meas_req            <= 1'b0;
			o_battery_good_output <= 1'b0;
			o_wake_cmp_en         <= 1'b0;
			o_wake_range_select   <= 3'h0;
		end else begin
			// Fast clock stays up in light idle so no wake latency
			o_hfosc_en <= state_r != gpmc_pkg::ST_DEEP &&
			              state_r != gpmc_pkg::ST_HIB &&
			              state_r != gpmc_pkg::ST_INSCHK;
			o_cpu_halt <= state_r == gpmc_pkg::ST_INSCHK;
			o_algo_run <= measuring;
			o_meas_req <= measuring && i_meas_tick;
			if (state_r == gpmc_pkg::ST_INIT && i_ocv_done) begin
				o_battery_good_output <= 1'b1;
			end else if (!bat_pres_r) begin
				o_battery_good_output <= 1'b0;
			end
			o_wake_cmp_en <= ctrl_r[gpmc_pkg::CTRL_SNS_HI] ||
			                 ctrl_r[gpmc_pkg::CTRL_SNS_LO];
			o_wake_range_select <= {ctrl_r[gpmc_pkg::CTRL_SNS_HI],
			                        ctrl_r[gpmc_pkg::CTRL_SNS_LO],
			                        ctrl_r[gpmc_pkg::CTRL_WAKE_RNG]};
		end
	end

	// The size field is not decoded: only whole-word access is used
	logic unused_ok;
	assign unused_ok = ^i_hsize;

endmodule

// ---- logic/gpmc_pkg.sv ----
package gpmc_pkg;

	// ------------------------------------------------------------
	// Register map (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] REG_CTRL     = 8'h00;
	localparam logic [7:0] REG_IDLE_THR = 8'h04;
	localparam logic [7:0] REG_HIB_I    = 8'h08;
	localparam logic [7:0] REG_HIB_V    = 8'h0c;
	localparam logic [7:0] REG_CMD      = 8'h10;
	localparam logic [7:0] REG_STATUS   = 8'h14;

	// ------------------------------------------------------------
	// Control register fields and reset values
	// ------------------------------------------------------------
	localparam int CTRL_W        = 6;
	localparam int CTRL_LIGHT    = 0;
	localparam int CTRL_DEEP     = 1;
	localparam int CTRL_INSDET   = 2;
	localparam int CTRL_SNS_LO   = 3;
	localparam int CTRL_SNS_HI   = 4;
	localparam int CTRL_WAKE_RNG = 5;
	localparam logic [5:0]  CTRL_RST     = 6'h00;
	localparam logic [15:0] IDLE_THR_RST = 16'h000a;
	localparam logic [15:0] HIB_I_RST    = 16'h0008;
	localparam logic [15:0] HIB_V_RST    = 16'h0b54;

	// ------------------------------------------------------------
	// Status register fields
	// ------------------------------------------------------------
	localparam int ST_MODE_LSB  = 0;
	localparam int ST_OCV_DONE  = 3;
	localparam int ST_CAL_ACT   = 4;
	localparam int ST_HIB_REQ   = 5;
	localparam int ST_BAT_PRES  = 6;
	localparam int ST_LIGHT_EN  = 7;
	localparam int ST_PROF_LSB  = 8;

	// ------------------------------------------------------------
	// Host subcommands written to the command register
	// ------------------------------------------------------------
	localparam logic [7:0] CMD_SET_HIB   = 8'h01;
	localparam logic [7:0] CMD_BAT_PRES  = 8'h02;
	localparam logic [7:0] CMD_BAT_ABS   = 8'h03;
	localparam logic [5:0] CMD_PROF_BASE = 6'h01;

	// ------------------------------------------------------------
	// Mode codes shown in status
	// ------------------------------------------------------------
	localparam logic [2:0] MODE_NORMAL = 3'h0;
	localparam logic [2:0] MODE_LIGHT  = 3'h1;
	localparam logic [2:0] MODE_DEEP   = 3'h2;
	localparam logic [2:0] MODE_HIB    = 3'h3;
	localparam logic [2:0] MODE_INSCHK = 3'h4;
	localparam logic [2:0] MODE_CAL    = 3'h5;
	localparam logic [2:0] MODE_INIT   = 3'h6;

	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic       HRESP_OKAY    = 1'h0;

	typedef enum logic [2:0] {
		ST_NORMAL,
		ST_CAL,
		ST_LIGHT,
		ST_DEEP,
		ST_HIB,
		ST_INSCHK,
		ST_INSWAKE,
		ST_INIT
	} gpmc_state_e;

endpackage

// ---- sim/gpmc_chk.sv ----
`timescale 1ns/1ns

// ----------------------------------------
// Port watcher for the power-mode block
// ----------------------------------------
module gpmc_chk (
	input wire logic       i_sys_clk,
	input wire logic       i_resetn,
	input wire logic       i_meas_tick,
	input wire logic       i_i2c_addr_match,
	input wire logic       i_host_cmd,
	input wire logic       i_ocv_done,
	input wire logic       o_hreadyout,
	input wire logic       o_hresp,
	input wire logic       o_hfosc_en,
	input wire logic       o_cpu_halt,
	input wire logic       o_algo_run,
	input wire logic       o_meas_req,
	input wire logic       o_cal_start,
	input wire logic       o_ocv_start,
	input wire logic       o_battery_good_output,
	input wire logic       o_wake_cmp_en,
	input wire logic [2:0] o_wake_range_select
);
	logic hib;

	// Only hibernate has clock, halt and algorithm all off
	assign hib = !o_hfosc_en && !o_cpu_halt && !o_algo_run;

	default clocking dc @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_resetn);

	AST_HALT: assert property (
		o_cpu_halt |-> !o_hfosc_en && !o_algo_run)
		else $error("halted with clock or algorithm on");
	AST_WAKE_EN: assert property (
		o_wake_cmp_en == (|o_wake_range_select[2:1]))
		else $error("wake comparator enable wrong");
	AST_MEAS: assert property (
		o_meas_req |-> $past(i_meas_tick))
		else $error("measurement without tick");
	AST_CAL: assert property (
		o_cal_start |=> !o_cal_start && o_algo_run && o_hfosc_en)
		else $error("calibration start malformed");
	AST_OCV: assert property (
		o_ocv_start |=> !o_ocv_start)
		else $error("ocv start longer than a cycle");
	AST_HIB_HOLD: assert property (
		hib && !i_i2c_addr_match && !$past(i_i2c_addr_match) |=> hib)
		else $error("left hibernate without addressed traffic");
	AST_HIB_WAKE: assert property (
		hib && i_i2c_addr_match |-> ##[1:3] o_ocv_start)
		else $error("no reinitialisation after wake");
	AST_HALT_WAKE: assert property (
		o_cpu_halt && i_host_cmd |-> ##[1:3] !o_cpu_halt)
		else $error("host command not served");
	AST_BGOOD: assert property (
		$rose(o_battery_good_output)
		|-> $past(i_ocv_done) || $past(i_ocv_done, 2))
		else $error("battery good without ocv");
	AST_BUS: assert property (
		o_hreadyout && o_hresp == gpmc_pkg::HRESP_OKAY)
		else $error("bus slave stalled or erred");

	cover property (o_cal_start);
	cover property (hib ##1 i_i2c_addr_match);
	cover property (o_cpu_halt && i_host_cmd);
endmodule

bind gpmc_top gpmc_chk i_gpmc_chk (
	.i_sys_clk, .i_resetn, .i_meas_tick, .i_i2c_addr_match,
	.i_host_cmd, .i_ocv_done, .o_hreadyout, .o_hresp, .o_hfosc_en,
	.o_cpu_halt, .o_algo_run, .o_meas_req, .o_cal_start, .o_ocv_start,
	.o_battery_good_output, .o_wake_cmp_en, .o_wake_range_select
);

// ---- sim/gpmc_afe_model.sv ----
`timescale 1ns/1ns

// ----------------------------------------
// Measurement front end on the far side
// ----------------------------------------
module gpmc_afe_model (
	input  wire logic       i_sys_clk,
	input  wire logic       i_resetn,
	input  wire logic [7:0] i_dly,
	input  wire logic       i_cal_start,
	input  wire logic       i_ocv_start,
	output logic            o_cal_done,
	output logic            o_ocv_done
);
	logic [7:0] cal_cnt_r;
	logic [7:0] ocv_cnt_r;

	// Offset calibration ends after i_dly cycles
	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			cal_cnt_r  <= 8'h00;
			o_cal_done <= 1'b0;
		end else begin
			o_cal_done <= cal_cnt_r == 8'h01;
			if (i_cal_start)
				cal_cnt_r <= i_dly;
			else if (cal_cnt_r != 8'h00)
				cal_cnt_r <= cal_cnt_r - 8'h01;
		end
	end

	// Load kept light, so the reading settles after i_dly
	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			ocv_cnt_r  <= 8'h00;
			o_ocv_done <= 1'b0;
		end else begin
			o_ocv_done <= ocv_cnt_r == 8'h01;
			if (i_ocv_start)
				ocv_cnt_r <= i_dly;
			else if (ocv_cnt_r != 8'h00)
				ocv_cnt_r <= ocv_cnt_r - 8'h01;
		end
	end
endmodule

// ---- sim/gpmc_top_tb.sv ----
`timescale 1ns/1ns

module gpmc_top_tb;
	logic [31:0]        o_hrdata;
	logic               o_hreadyout, o_hresp, o_hfosc_en, o_cpu_halt;
	logic               o_algo_run, o_meas_req, o_cal_start, o_ocv_start;
	logic               o_battery_good_output, o_profile_load;
	logic               o_wake_cmp_en;
	logic [1:0]         o_profile_sel;
	logic [2:0]         o_wake_range_select;
	logic               i_sys_clk = 1'b0;
	logic               i_resetn = 1'b0;
	logic               i_hsel = 1'b0;
	logic [7:0]         i_haddr = 8'h00;
	logic [1:0]         i_htrans = 2'h0;
	logic               i_hwrite = 1'b0;
	logic [2:0]         i_hsize = 3'h2;
	logic [31:0]        i_hwdata = 32'h0;
	logic signed [15:0] i_current = 16'sh0;
	logic signed [15:0] i_avg_current = 16'sh0;
	logic [15:0]        i_voltage = 16'hffff;
	logic [4:0]         ev = 5'h00;
	logic               i_wake_cmp = 1'b0;
	logic               i_ext_power = 1'b0;
	logic               i_battery_insert_pin = 1'b0;
	logic               i_therm_present = 1'b0;
	logic [7:0]         dly = 8'h14;
	logic               rdp = 1'b0;
	logic [31:0]        eq[$], mq[$], v, m;
	logic [7:0]         ra[6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h18};
	logic [31:0]        rv[6] = '{0, 32'ha, 32'h8, 32'hb54, 0, 0};
	int                 n_mismatch = 0, n_compared = 0, cyc = 0;
	int                 nload = 0, nmeas = 0, r, n0;
	wire                i_hready = o_hreadyout;
	wire                i_meas_tick = ev[0];
	wire                i_host_activity = ev[1];
	wire                i_i2c_addr_match = ev[2];
	wire                i_host_cmd = ev[3];
	wire                i_host_cmd_done = ev[4];
	wire                i_cal_done, i_ocv_done;

	gpmc_top i_gpmc_top (
		.i_sys_clk, .i_resetn, .i_hsel, .i_haddr, .i_htrans, .i_hwrite,
		.i_hsize, .i_hready, .i_hwdata, .o_hrdata, .o_hreadyout, .o_hresp,
		.i_meas_tick, .i_current, .i_avg_current, .i_voltage,
		.i_host_activity, .i_i2c_addr_match, .i_host_cmd, .i_host_cmd_done,
		.i_cal_done, .i_ocv_done, .i_wake_cmp, .i_ext_power,
		.i_battery_insert_pin, .i_therm_present, .o_hfosc_en, .o_cpu_halt,
		.o_algo_run, .o_meas_req, .o_cal_start, .o_ocv_start,
		.o_battery_good_output, .o_profile_sel, .o_profile_load,
		.o_wake_cmp_en, .o_wake_range_select
	);

	gpmc_afe_model i_gpmc_afe_model (
		.i_sys_clk, .i_resetn, .i_dly(dly), .i_cal_start(o_cal_start),
		.i_ocv_start(o_ocv_start), .o_cal_done(i_cal_done),
		.o_ocv_done(i_ocv_done)
	);

	always #50 i_sys_clk = ~i_sys_clk;

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task stop_test;
		$display("compared %0d, mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic w(input int n);
		repeat (n) @(posedge i_sys_clk);
	endtask

	// Address phase held until hready, then data phase likewise
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		i_hsel <= 1'b1;
		i_htrans <= gpmc_pkg::HTRANS_NONSEQ;
		i_haddr <= a;
		i_hwrite <= wr;
		do @(posedge i_sys_clk); while (o_hreadyout !== 1'b1);
		i_hsel <= 1'b0;
		i_htrans <= 2'h0;
		i_hwdata <= d;
		do @(posedge i_sys_clk); while (o_hreadyout !== 1'b1);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] mk, input logic [31:0] e);
		mq.push_back(mk);
		eq.push_back(e & mk);
		bus(1'b0, a, 32'h0);
	endtask

	task automatic st(input logic [31:0] mk, input logic [31:0] e);
		rd(gpmc_pkg::REG_STATUS, mk, e);
	endtask

	task automatic md(input logic [2:0] md_code);
		st(32'h7, {29'h0, md_code});
	endtask

	task automatic pulse(input int k, input int n);
		ev[k] <= 1'b1;
		@(posedge i_sys_clk);
		ev[k] <= 1'b0;
		w(n);
	endtask

	task automatic wk;
		i_wake_cmp <= 1'b1;
		w(3);
		i_wake_cmp <= 1'b0;
		w(6);
	endtask

	// ----------------------------------------
	// Watcher: read data against oldest note
	// ----------------------------------------
	always @(posedge i_sys_clk) begin
		cyc++;
		if (o_profile_load === 1'b1)
			nload++;
		if (o_meas_req === 1'b1)
			nmeas++;
		if (rdp && o_hreadyout === 1'b1) begin
			m = mq.pop_front();
			check(o_hrdata & m, eq.pop_front());
		end
		rdp <= i_hsel && i_htrans == gpmc_pkg::HTRANS_NONSEQ && !i_hwrite;
		// Run needs well under a thousand cycles
		if (cyc == 3000) begin
			n_mismatch++;
			stop_test;
		end
	end

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		r = $urandom(19122);
		w(4);
		i_resetn <= 1'b1;
		w(30);
		md(gpmc_pkg::MODE_NORMAL);
		st(32'h8, 32'h8);
		for (int i = 0; i < 6; i++)
			rd(ra[i], '1, rv[i]);
		for (int i = 1; i < 4; i++) begin
			v = $urandom;
			wr(ra[i], v);
			rd(ra[i], '1, {16'h0, v[15:0]});
			wr(ra[i], rv[i]);
		end
		wr(8'h18, '1);
		wr(gpmc_pkg::REG_STATUS, '1);
		rd(8'h18, '1, 32'h0);
		md(gpmc_pkg::MODE_NORMAL);
		$display("register test done");
		i_current <= 16'($urandom_range(9, 0));
		wr(gpmc_pkg::REG_CTRL, 32'h01);
		check(32'(o_wake_cmp_en), 32'h0);
		pulse(0, 3);
		st(32'h87, 32'h81);
		wk;
		md(gpmc_pkg::MODE_LIGHT);
		check(32'(o_hfosc_en), 32'h1);
		wr(gpmc_pkg::REG_CTRL, 32'h31);
		w(2);
		check(32'(o_wake_range_select), 32'h5);
		check(32'(o_wake_cmp_en), 32'h1);
		for (int k = 0; k < 3; k++) begin
			n0 = nmeas;
			pulse(0, 3);
			check(32'(nmeas - n0), 32'h1);
			md(gpmc_pkg::MODE_LIGHT);
			case (k)
			0: pulse(1, 6);
			1: begin
				i_current <= 16'shff00;
				pulse(0, 6);
			end
			default: wk;
			endcase
			md(gpmc_pkg::MODE_NORMAL);
			i_current <= 16'($urandom_range(9, 0));
		end
		$display("light idle test done");
		wr(gpmc_pkg::REG_CTRL, 32'h0b);
		for (int k = 0; k < 2; k++) begin
			pulse(0, 3);
			st(32'h17, 32'h15);
			w(25);
			md(gpmc_pkg::MODE_DEEP);
			check(32'(o_hfosc_en), 32'h0);
			if (k == 0) begin
				wk;
			end else begin
				i_current <= 16'sh0100;
				pulse(0, 6);
			end
			md(gpmc_pkg::MODE_NORMAL);
			i_current <= 16'($urandom_range(9, 0));
		end
		$display("deep idle test done");
		wr(gpmc_pkg::REG_CTRL, 32'h0);
		i_avg_current <= 16'sh0040;
		wr(gpmc_pkg::REG_CMD, {24'h0, gpmc_pkg::CMD_SET_HIB});
		// Command strobe acts one cycle after its data phase
		w(1);
		st(32'h20, 32'h20);
		pulse(0, 4);
		md(gpmc_pkg::MODE_NORMAL);
		i_avg_current <= 16'shfffd;
		pulse(0, 4);
		md(gpmc_pkg::MODE_HIB);
		pulse(1, 6);
		md(gpmc_pkg::MODE_HIB);
		check(32'(o_hfosc_en), 32'h0);
		pulse(2, 30);
		st(32'h2f, 32'h08);
		i_avg_current <= 16'sh0040;
		i_voltage <= 16'h0b53;
		pulse(0, 4);
		md(gpmc_pkg::MODE_HIB);
		i_voltage <= 16'hffff;
		pulse(2, 30);
		md(gpmc_pkg::MODE_NORMAL);
		$display("hibernate test done");
		wr(gpmc_pkg::REG_CTRL, 32'h04);
		i_ext_power <= 1'b1;
		w(8);
		md(gpmc_pkg::MODE_INSCHK);
		check(32'({o_cpu_halt, o_algo_run}), 32'h2);
		pulse(3, 3);
		check(32'(o_cpu_halt), 32'h0);
		pulse(4, 3);
		check(32'(o_cpu_halt), 32'h1);
		i_battery_insert_pin <= 1'b1;
		w(35);
		st(32'h4f, 32'h48);
		check(32'(o_battery_good_output), 32'h1);
		wr(gpmc_pkg::REG_CTRL, 32'h0);
		i_battery_insert_pin <= 1'b0;
		wr(gpmc_pkg::REG_CMD, {24'h0, gpmc_pkg::CMD_BAT_ABS});
		w(6);
		md(gpmc_pkg::MODE_INSCHK);
		check(32'(o_battery_good_output), 32'h0);
		wr(gpmc_pkg::REG_CMD, {24'h0, gpmc_pkg::CMD_BAT_PRES});
		w(30);
		md(gpmc_pkg::MODE_NORMAL);
		for (int k = 0; k < 4; k++) begin
			n0 = nload;
			wr(gpmc_pkg::REG_CMD, {24'h0, gpmc_pkg::CMD_PROF_BASE, 2'(k)});
			w(4);
			check(32'(o_profile_sel), 32'(k));
			check(32'(nload - n0), 32'h1);
			st(32'h300, 32'(k) << 8);
		end
		$display("insertion test done");
		// Let the last read reach the watcher before the verdict
		w(2);
		check(32'(eq.size()), 32'h0);
		stop_test;
	end
endmodule
